// file: hdl/asp_pkg.sv
package asp_pkg;
  localparam int ASP_ADDR_W       = 19;
  localparam int ASP_DATA_W       = 8;
  localparam int ASP_CLK_PERIOD_NS = 10;
  // fastest grade figures, ns
  localparam int ASP_T_RC_NS      = 10;
  localparam int ASP_T_AA_NS      = 10;
  localparam int ASP_T_OE_NS      = 5;
  localparam int ASP_T_OHZ_NS     = 5;
  localparam int ASP_T_WC_NS      = 10;
  localparam int ASP_T_WP_NS      = 8;
  localparam int ASP_T_AW_NS      = 8;
  localparam int ASP_T_DW_NS      = 6;
  localparam int ASP_T_WHZ_NS     = 6;
  localparam int ASP_T_OW_NS      = 3;
  // cycle counts: least times round up, at least one
  function automatic int asp_up(input int ns);
    int c;
    c = (ns + ASP_CLK_PERIOD_NS - 1) / ASP_CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : asp_up
  // access time, then both synchroniser stages before capture
  localparam int ASP_RD_CYC  = asp_up(ASP_T_AA_NS) + 2;
  localparam int ASP_WP_CYC  = asp_up(ASP_T_WP_NS);
  localparam int ASP_WPOE_CYC = asp_up(ASP_T_WHZ_NS + ASP_T_DW_NS);
  localparam int ASP_WC_CYC  = asp_up(ASP_T_WC_NS);
  localparam int ASP_HZ_CYC  = asp_up(ASP_T_OHZ_NS);
  localparam int ASP_CNT_W   = 4;
endpackage : asp_pkg

// file: hdl/asp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asp_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk_in) begin
    meta_reg <= d_in;
    q_out    <= meta_reg;
  end
endmodule : asp_pin_sync
`default_nettype wire

// file: hdl/asp_sram_host.sv
`timescale 1ns/1ps
`default_nettype none
module asp_sram_host
  import asp_pkg::*;
#(
  parameter int ADDR_W = ASP_ADDR_W,
  parameter int DATA_W = ASP_DATA_W
) (
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_index_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  output var  logic              req_ready_out,
  output var  logic              rd_valid_out,
  output var  logic [DATA_W-1:0] rd_data_out,
  output var  logic [ADDR_W-1:0] word_index_out,
  output var  logic              chip_sel_n_out,
  output var  logic              write_strobe_n_out,
  output var  logic              out_drive_n_out,
  input  wire logic [DATA_W-1:0] byte_lanes_in,
  output var  logic [DATA_W-1:0] byte_lanes_out,
  output var  logic              byte_lanes_oe_out
);
  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ASP_IDLE, ASP_RD, ASP_RD_HZ, ASP_WR_SETUP, ASP_WR_PULSE, ASP_WR_REC
  } asp_state_t;

  asp_state_t            state_reg;
  logic [ASP_CNT_W-1:0]  cnt_reg;
  logic [DATA_W-1:0]     lanes_sync;

  asp_pin_sync #(.WIDTH(DATA_W)) u_sync (
    .clk_in (clk_in),
    .d_in   (byte_lanes_in),
    .q_out  (lanes_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  localparam int WR_PULSE_CYC = (ASP_WP_CYC > ASP_WPOE_CYC) ? ASP_WP_CYC
                                                            : ASP_WPOE_CYC;
  logic                  take;
  logic                  cnt_zero;
  logic                  rd_done;

  assign take     = (state_reg == ASP_IDLE) && req_valid_in && req_ready_out;
  assign cnt_zero = (cnt_reg == ASP_CNT_W'(0));
  assign rd_done  = (state_reg == ASP_RD) && cnt_zero;

  ////////////////////////////////////////////////////////////////////////
  // sequencer state
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= ASP_IDLE;
    end else begin
      unique case (state_reg)
        ASP_IDLE: begin
          if (take && req_write_in) begin
            // output drive stays high, write strobe after chip select
            state_reg <= ASP_WR_SETUP;
          end else if (take) begin
            state_reg <= ASP_RD;
          end
        end
        ASP_RD: begin
          if (cnt_zero) begin
            state_reg <= ASP_RD_HZ;
          end
        end
        ASP_RD_HZ: begin
          // let device float before anyone drives the bus
          if (cnt_zero) begin
            state_reg <= ASP_IDLE;
          end
        end
        ASP_WR_SETUP: begin
          state_reg <= ASP_WR_PULSE;
        end
        ASP_WR_PULSE: begin
          if (cnt_zero) begin
            state_reg <= ASP_WR_REC;
          end
        end
        ASP_WR_REC: begin
          state_reg <= ASP_IDLE;
        end
        default: begin
          state_reg <= ASP_IDLE;
        end
      endcase
    end
  end

  // wait counter
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ASP_IDLE: begin
          if (take && !req_write_in) begin
            cnt_reg <= ASP_CNT_W'(ASP_RD_CYC);
          end
        end
        ASP_RD: begin
          // hold strobes until data settled and synchronised
          if (cnt_zero) begin
            cnt_reg <= ASP_CNT_W'(ASP_HZ_CYC);
          end else begin
            cnt_reg <= cnt_reg - ASP_CNT_W'(1);
          end
        end
        ASP_RD_HZ, ASP_WR_PULSE: begin
          if (!cnt_zero) begin
            cnt_reg <= cnt_reg - ASP_CNT_W'(1);
          end
        end
        ASP_WR_SETUP: begin
          cnt_reg <= ASP_CNT_W'(WR_PULSE_CYC - 1);
        end
        ASP_WR_REC: begin
          cnt_reg <= cnt_reg;
        end
        default: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request handshake
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      req_ready_out <= 1'b0;
    end else begin
      req_ready_out <= (state_reg == ASP_IDLE) && !take;
    end
  end

  // pin strobes and index
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      word_index_out <= '0;
    end else if (take) begin
      word_index_out <= req_index_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      chip_sel_n_out <= 1'b1;
    end else if (take) begin
      chip_sel_n_out <= 1'b0;
    end else if (rd_done || state_reg == ASP_WR_REC) begin
      chip_sel_n_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      write_strobe_n_out <= 1'b1;
    end else if (state_reg == ASP_WR_SETUP) begin
      write_strobe_n_out <= 1'b0;
    end else if (state_reg == ASP_WR_PULSE && cnt_zero) begin
      write_strobe_n_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      out_drive_n_out <= 1'b1;
    end else if (take && !req_write_in) begin
      out_drive_n_out <= 1'b0;
    end else if (rd_done) begin
      out_drive_n_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write data drive
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      byte_lanes_out <= '0;
    end else if (take && req_write_in) begin
      byte_lanes_out <= req_wdata_in;
    end
  end

  // data held past write end, then release
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      byte_lanes_oe_out <= 1'b0;
    end else if (state_reg == ASP_WR_SETUP) begin
      byte_lanes_oe_out <= 1'b1;
    end else if (state_reg == ASP_WR_REC) begin
      byte_lanes_oe_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data capture, pin value trails by two edges
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end else begin
      rd_valid_out <= rd_done;
      if (rd_done) begin
        rd_data_out <= lanes_sync;
      end
    end
  end
endmodule : asp_sram_host
`default_nettype wire

// file: verification/asp_sram_host_props.sv
`timescale 1ns/1ps
`default_nettype none
module asp_sram_host_props #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8
) (
  input wire logic              clk_in,
  input wire logic              sys_rst_in,
  input wire logic              req_valid_in,
  input wire logic              req_write_in,
  input wire logic              req_ready_out,
  input wire logic [ADDR_W-1:0] req_index_in,
  input wire logic              rd_valid_out,
  input wire logic [ADDR_W-1:0] word_index_out,
  input wire logic              chip_sel_n_out,
  input wire logic              write_strobe_n_out,
  input wire logic              out_drive_n_out,
  input wire logic [DATA_W-1:0] byte_lanes_out,
  input wire logic              byte_lanes_oe_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic tk = req_valid_in && req_ready_out;
  AST_RD_ANS: assert property (tk && !req_write_in |-> ##5 rd_valid_out)
    else $error("read answer late");
  AST_RD_SEL: assert property (tk && !req_write_in |=>
    !chip_sel_n_out && !out_drive_n_out && write_strobe_n_out)
    else $error("read strobes wrong");
  AST_INDEX: assert property (tk |=> word_index_out == $past(req_index_in))
    else $error("index not presented");
  AST_NO_FIGHT: assert property (!byte_lanes_oe_out || out_drive_n_out)
    else $error("bus contention");
  AST_WE_CS: assert property (!write_strobe_n_out |-> !chip_sel_n_out)
    else $error("strobe without select");
  AST_WR_SEQ: assert property (tk && req_write_in |-> ##1 !chip_sel_n_out
    ##1 !write_strobe_n_out [*2] ##1 write_strobe_n_out)
    else $error("write pulse wrong");
  AST_DATA: assert property (!write_strobe_n_out |-> byte_lanes_oe_out
    && $stable(byte_lanes_out))
    else $error("write data not held");
  AST_GAP: assert property ($rose(chip_sel_n_out) |=> chip_sel_n_out)
    else $error("cycles too close");
  COV_RD: cover property (rd_valid_out);
  COV_WR: cover property ($rose(write_strobe_n_out));
  COV_WAIT: cover property (req_valid_in && !req_ready_out);
endmodule : asp_sram_host_props
bind asp_sram_host asp_sram_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  chk (.*);
`default_nettype wire

// file: verification/asp_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module asp_sram_model
  import asp_pkg::*;
(
  input  wire logic [18:0] word_index_in,
  input  wire logic        chip_sel_n_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        out_drive_n_in,
  input  wire logic [7:0]  byte_lanes_in,
  output var  logic [7:0]  byte_lanes_out,
  output var  logic        drive_out
);
  logic [7:0] mem [logic [18:0]];
  logic       wr_was = 1'b0;
  // drives only when read strobes line up
  wire logic  drv_now = !chip_sel_n_in && !out_drive_n_in
    && write_strobe_n_in;
  initial drive_out = 1'b0;
  initial byte_lanes_out = 8'h00;
  // byte lands when the select and strobe overlap ends
  always @(chip_sel_n_in or write_strobe_n_in) begin
    if (wr_was && (chip_sel_n_in || write_strobe_n_in))
      mem[word_index_in] = byte_lanes_in;
    wr_was = (chip_sel_n_in === 1'b0) && (write_strobe_n_in === 1'b0);
  end
  // pins turn on and off only after the pin delays
  always @(drv_now) drive_out <= #(ASP_T_OE_NS) drv_now;
  // old byte holds, new one valid only after the access time
  always @(word_index_in or drv_now)
    byte_lanes_out <= #(ASP_T_AA_NS) mem.exists(word_index_in)
      ? mem[word_index_in] : 8'h00;
endmodule : asp_sram_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
  import asp_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, valid = 0, wr = 0, mdrv, oe, cs, we, od;
  logic [18:0] idx = 0, wix;
  logic [7:0]  wd = 0, lanes, hout, mout, last = 0;
  int errors = 0, checks = 0, cyc = 0;
  wire logic rdv, rdy;
  wire logic [7:0] rdd;
  asp_sram_host uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .req_valid_in(valid), .req_write_in(wr), .req_index_in(idx),
    .req_wdata_in(wd), .req_ready_out(rdy), .rd_valid_out(rdv),
    .rd_data_out(rdd), .word_index_out(wix), .chip_sel_n_out(cs),
    .write_strobe_n_out(we), .out_drive_n_out(od), .byte_lanes_in(lanes),
    .byte_lanes_out(hout), .byte_lanes_oe_out(oe));
  asp_sram_model mdl (.word_index_in(wix), .chip_sel_n_in(cs),
    .write_strobe_n_in(we), .out_drive_n_in(od), .byte_lanes_in(lanes),
    .byte_lanes_out(mout), .drive_out(mdrv));
  // floating bus shows a changing pattern
  assign lanes = oe ? hout : (mdrv ? mout : ~last);
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    last <= lanes;
    cyc <= cyc + 1;
    if (oe === 1'b1) `CHK("bus_fight", 1'b0, mdrv)
    if (cyc == 3000) begin errors++; end_of_test(); end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic req(input logic w, input logic [18:0] i, input logic [7:0] d);
    @(negedge clk_in);
    valid = 1; wr = w; idx = i; wd = d;
    do @(posedge clk_in); while (rdy !== 1'b1);
    @(negedge clk_in);
    valid = 0;
  endtask : req
  task automatic rd(input logic [18:0] i, input logic [7:0] e);
    int n;
    req(0, i, 8'h00);
    for (n = 0; n < 20 && rdv !== 1'b1; n++) begin @(posedge clk_in); #1; end
    `CHK("rd_valid", 1'b1, rdv)
    `CHK("rd_latency", ASP_RD_CYC + 1, n)
    `CHK("rd_data", e, rdd)
  endtask : rd
  task automatic t_idle();
    `CHK("cs_n", 1'b1, cs)
    `CHK("lanes_oe", 1'b0, oe)
    `CHK("ready", 1'b1, rdy)
  endtask : t_idle
  task automatic t_bounds();
    req(1, 19'h00000, 8'ha5);
    req(1, 19'h7ffff, 8'h5a);
    rd(19'h00000, 8'ha5);
    rd(19'h7ffff, 8'h5a);
  endtask : t_bounds
  task automatic t_overwrite();
    req(1, 19'h12345, 8'h3c);
    req(1, 19'h12345, 8'hc3);
    rd(19'h12345, 8'hc3);
    rd(19'h00000, 8'ha5);
  endtask : t_overwrite
  task automatic t_reset();
    req(0, 19'h00000, 8'h00);
    sys_rst_in = 1;
    @(negedge clk_in);
    `CHK("rst_cs_n", 1'b1, cs)
    `CHK("rst_out_drive_n", 1'b1, od)
    `CHK("rst_ready", 1'b0, rdy)
    sys_rst_in = 0;
    repeat (6) begin
      @(negedge clk_in);
      `CHK("rst_no_answer", 1'b0, rdv)
    end
  endtask : t_reset
  initial begin
    repeat (8) @(negedge clk_in);
    sys_rst_in = 0;
    repeat (3) @(negedge clk_in);
    t_idle();
    t_bounds();
    t_overwrite();
    t_reset();
    t_idle();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
